// File: verilog/ptmr_timer.sv
// Periodic 10-bit timer with compare, PWM, single pulse and capture modes
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_map.svh"

module ptmr_timer #(
    parameter int PRESCALE = `PTMR_PRESCALE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire ptmr_pkg::ptmr_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins
    input wire logic timer_io_pin_in,
    output logic timer_io_pin_out,
    output logic timer_io_pin_oe_n,
    input wire logic timer_clock_pin
);
    import ptmr_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    ptmr_ctrl_t ctrl_reg;
    ptmr_cksel_t cksel_reg;
    logic counter_on_reg;
    logic on_prev_reg;
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [9:0] compare_a_value_reg;
    logic [7:0] period_lo_reg;
    logic [7:0] period_high_byte_reg;
    logic match_a_flag_reg;
    logic match_p_flag_reg;
    logic out_lvl_reg;
    logic [1:0] div_reg;
    logic io_s1_reg, io_s2_reg, io_s3_reg;
    logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic io_out_reg;
    logic io_oe_n_reg;

    // ----------------------------------------------------------------
    // Derived signals
    // ----------------------------------------------------------------
    logic [9:0] period_value;
    logic [9:0] inc;
    logic on_rise;
    logic tick;
    logic hit_a, hit_p, clr_cnt;
    logic cap_edge;
    logic io_rise, io_fall, ck_rise, ck_fall;
    logic src_rise, src_fall;
    logic is_cmp_like, is_single;
    logic pwm_active;
    logic [10:0] pwm_period;
    logic bus_access, bus_wr, bus_rd_cycle;
    logic addr_ok;
    logic [31:0] rd_mux;

    assign period_value = {period_high_byte_reg[1:0], period_lo_reg};
    assign inc = cnt_reg + 10'h001;
    assign on_rise = counter_on_reg & ~on_prev_reg;
    assign is_cmp_like = (ctrl_reg.mode_select == PTMR_MODE_CMP) ||
                         (ctrl_reg.mode_select == PTMR_MODE_TC);
    assign is_single = (ctrl_reg.mode_select == PTMR_MODE_PWM) &&
                       (ctrl_reg.pin_function == 2'h3);

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            io_s1_reg <= 1'b0;
            io_s2_reg <= 1'b0;
            io_s3_reg <= 1'b0;
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
        end else begin
            io_s1_reg <= timer_io_pin_in;
            io_s2_reg <= io_s1_reg;
            io_s3_reg <= io_s2_reg;
            ck_s1_reg <= timer_clock_pin;
            ck_s2_reg <= ck_s1_reg;
            ck_s3_reg <= ck_s2_reg;
        end
    end

    assign io_rise = io_s2_reg & ~io_s3_reg;
    assign io_fall = ~io_s2_reg & io_s3_reg;
    assign ck_rise = ck_s2_reg & ~ck_s3_reg;
    assign ck_fall = ~ck_s2_reg & ck_s3_reg;

    // ----------------------------------------------------------------
    // Timer clock tick
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= 2'h0;
        end else if (div_reg == 2'(PRESCALE - 1)) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    always_comb begin
        case (cksel_reg)
            PTMR_CK_SYS: tick = 1'b1;
            PTMR_CK_DIV: tick = (div_reg == 2'h0);
            PTMR_CK_PIN_RISE: tick = ck_rise;
            default: tick = ck_fall;
        endcase
    end

    // ----------------------------------------------------------------
    // Capture edge selection
    // ----------------------------------------------------------------
    assign src_rise = ctrl_reg.capture_source_select ? ck_rise : io_rise;
    assign src_fall = ctrl_reg.capture_source_select ? ck_fall : io_fall;

    always_comb begin
        case (ctrl_reg.pin_function)
            2'h0: cap_edge = src_rise;
            2'h1: cap_edge = src_fall;
            2'h2: cap_edge = src_rise | src_fall;
            default: cap_edge = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Comparators: a match is seen as the counter is about to reach
    // the compare value, so it counts 0 .. value-1
    // ----------------------------------------------------------------
    always_comb begin
        hit_a = 1'b0;
        hit_p = 1'b0;
        clr_cnt = 1'b0;
        if (counter_on_reg && !on_rise && tick) begin
            case (ctrl_reg.mode_select)
                PTMR_MODE_CMP, PTMR_MODE_TC: begin
                    // Zero compare A means plain overflow, no A flag
                    hit_a = (inc == compare_a_value_reg) &&
                            (compare_a_value_reg != 10'h000);
                    if (ctrl_reg.clear_source_select) begin
                        clr_cnt = hit_a;
                    end else begin
                        // Period zero matches as the count wraps
                        hit_p = (inc == period_value);
                        clr_cnt = hit_p;
                    end
                end
                PTMR_MODE_PWM: begin
                    hit_a = (inc == compare_a_value_reg);
                    if (!is_single) begin
                        hit_p = (inc == period_value);
                        clr_cnt = hit_p;
                    end
                end
                default: begin
                    hit_a = 1'b0;
                    hit_p = (inc == period_value);
                    clr_cnt = hit_p;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_comb begin
        if (on_rise) begin
            cnt_next = `PTMR_RST_VAL;
        end else if (counter_on_reg && tick) begin
            // Wraps after 3ff by width
            cnt_next = clr_cnt ? `PTMR_RST_VAL : inc;
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= `PTMR_RST_VAL;
            on_prev_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            on_prev_reg <= counter_on_reg;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: one wait state, answer in the second access cycle
    // ----------------------------------------------------------------
    assign bus_access = apb_req.psel & apb_req.penable;
    assign bus_wr = bus_access & pready_reg & apb_req.pwrite & addr_ok;
    assign bus_rd_cycle = bus_access & ~pready_reg;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        if (apb_req.paddr == `PTMR_OFF_CTRL0) begin
            rd_mux = {26'h0, cksel_reg, counter_on_reg, 3'h0};
        end else if (apb_req.paddr == `PTMR_OFF_CTRL1) begin
            rd_mux = {24'h0, ctrl_reg};
        end else if (apb_req.paddr == `PTMR_OFF_COUNT) begin
            rd_mux = {22'h0, cnt_reg};
        end else if (apb_req.paddr == `PTMR_OFF_CMPA) begin
            rd_mux = {22'h0, compare_a_value_reg};
        end else if (apb_req.paddr == `PTMR_OFF_PER_LO) begin
            rd_mux = {24'h0, period_lo_reg};
        end else if (apb_req.paddr == `PTMR_OFF_PER_HI) begin
            rd_mux = {30'h0, period_high_byte_reg[1:0]};
        end else if (apb_req.paddr == `PTMR_OFF_FLAGS) begin
            rd_mux = {30'h0, match_p_flag_reg, match_a_flag_reg};
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= bus_rd_cycle;
            if (bus_rd_cycle) begin
                prdata_reg <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_reg <= ~addr_ok;
            end else begin
                prdata_reg <= 32'h0000_0000;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control and value registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= ptmr_ctrl_t'(`PTMR_RST_CTRL);
            cksel_reg <= PTMR_CK_SYS;
            period_lo_reg <= 8'h00;
            period_high_byte_reg <= `PTMR_RST_PER_HI;
        end else if (bus_wr) begin
            if (apb_req.paddr == `PTMR_OFF_CTRL0) begin
                cksel_reg <= ptmr_cksel_t'(apb_req.pwdata[5:4]);
            end else if (apb_req.paddr == `PTMR_OFF_CTRL1) begin
                ctrl_reg <= ptmr_ctrl_t'(apb_req.pwdata[7:0]);
            end else if (apb_req.paddr == `PTMR_OFF_PER_LO) begin
                period_lo_reg <= apb_req.pwdata[7:0];
            end else if (apb_req.paddr == `PTMR_OFF_PER_HI) begin
                period_high_byte_reg <= {6'h00, apb_req.pwdata[1:0]};
            end
        end
    end

    // Counter-on: a hardware set beats a software clear, a software
    // write beats the hardware clear at the end of a single pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_on_reg <= 1'b0;
        end else if (is_single && !counter_on_reg && ck_rise) begin
            counter_on_reg <= 1'b1;
        end else if (bus_wr && apb_req.paddr == `PTMR_OFF_CTRL0) begin
            counter_on_reg <= apb_req.pwdata[`PTMR_CTRL0_ON];
        end else if (is_single && hit_a) begin
            counter_on_reg <= 1'b0;
        end
    end

    // Compare A: a capture wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_a_value_reg <= `PTMR_RST_VAL;
        end else if (ctrl_reg.mode_select == PTMR_MODE_CAP &&
                     counter_on_reg && cap_edge) begin
            compare_a_value_reg <= cnt_reg;
        end else if (bus_wr && apb_req.paddr == `PTMR_OFF_CMPA) begin
            compare_a_value_reg <= apb_req.pwdata[9:0];
        end
    end

    // ----------------------------------------------------------------
    // Match flags: write one to clear, a new event wins over the clear
    // ----------------------------------------------------------------
    logic flag_a_set;
    logic flag_clr_a, flag_clr_p;

    assign flag_a_set = hit_a | (ctrl_reg.mode_select == PTMR_MODE_CAP &&
                                 counter_on_reg && cap_edge);
    assign flag_clr_a = bus_wr && apb_req.paddr == `PTMR_OFF_FLAGS &&
                        apb_req.pwdata[`PTMR_FLAG_A];
    assign flag_clr_p = bus_wr && apb_req.paddr == `PTMR_OFF_FLAGS &&
                        apb_req.pwdata[`PTMR_FLAG_P];

    always_ff @(posedge clk) begin
        if (rst) begin
            match_a_flag_reg <= 1'b0;
        end else if (flag_a_set) begin
            match_a_flag_reg <= 1'b1;
        end else if (flag_clr_a) begin
            match_a_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            match_p_flag_reg <= 1'b0;
        end else if (hit_p) begin
            match_p_flag_reg <= 1'b1;
        end else if (flag_clr_p) begin
            match_p_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Compare-match output level
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            out_lvl_reg <= 1'b0;
        end else if (on_rise) begin
            out_lvl_reg <= ctrl_reg.initial_level;
        end else if (hit_a) begin
            // Of the two matches only an A match moves the pin
            case (ctrl_reg.pin_function)
                2'h1: out_lvl_reg <= 1'b0;
                2'h2: out_lvl_reg <= 1'b1;
                2'h3: out_lvl_reg <= ~out_lvl_reg;
                default: out_lvl_reg <= out_lvl_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // PWM duty: full duty when compare A reaches the period
    // ----------------------------------------------------------------
    assign pwm_period = (period_value == 10'h000) ? 11'h400 :
                        {1'b0, period_value};
    assign pwm_active = ({1'b0, compare_a_value_reg} >= pwm_period) ||
                        (cnt_reg < compare_a_value_reg);

    // ----------------------------------------------------------------
    // Output pin
    // ----------------------------------------------------------------
    logic act;

    always_comb begin
        case (ctrl_reg.pin_function)
            2'h0: act = 1'b0;
            2'h1: act = 1'b1;
            2'h2: act = counter_on_reg & pwm_active;
            default: act = counter_on_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_out_reg <= 1'b0;
            io_oe_n_reg <= 1'b1;
        end else begin
            case (ctrl_reg.mode_select)
                PTMR_MODE_CMP: begin
                    io_out_reg <= out_lvl_reg ^ ctrl_reg.output_invert;
                    io_oe_n_reg <= 1'b0;
                end
                PTMR_MODE_PWM: begin
                    // Active level comes from the initial-level bit
                    io_out_reg <= (act ? ctrl_reg.initial_level :
                                   ~ctrl_reg.initial_level) ^
                                  ctrl_reg.output_invert;
                    io_oe_n_reg <= 1'b0;
                end
                default: begin
                    // Pin released for other functions
                    io_out_reg <= 1'b0;
                    io_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign timer_io_pin_out = io_out_reg;
    assign timer_io_pin_oe_n = io_oe_n_reg;

endmodule // ptmr_timer

`default_nettype wire

// File: verilog/ptmr_map.svh
// Register map, field positions, reset values and counts of the timer
// Function
// - Two-bit mode field: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer.
// - Compare mode, clear source low: P match or overflow clears; both flags.
// - Compare mode, clear source high: A match clears; only A flag raised.
// - Compare A zero: counter overflows at 3ff without raising A flag.
// - Compare mode pin changes only on A match or rising counter-on; P match leaves it.
// - On A match pin goes high, low or toggles; field zero means unchanged.
// - Compare mode: rising counter-on drives output pin to initial level, flipped by invert.
// - Timer/counter mode acts like compare mode but leaves pin undriven.
// - PWM: period match clears counter, 0 means 1024; A sets duty.
// - PWM duty at or above period gives output active whole period.
// - PWM: initial level sets active level, function forces, invert flips.
// - PWM counter keeps running while the output is forced fixed.
// - Single pulse starts on rising counter-on, set by software or pin.
// - Single pulse: A match clears counter-on, ends pulse, raises flag.
// - Single pulse: counter zeroes only on rising on-bit; period unused.
// - Capture: source bit picks io or clock pin; function picks edges.
// - Capture edge copies counter into compare A and raises flag.
// - Capture: counter free runs, period match zeroes it, flag raised.
// - Capture with function 11 captures nothing but counter runs.
// - Rising on-bit zeroes counter; falling on-bit freezes it.
// - Capture edges: 00 rising, 01 falling, 10 both, 11 disabled.
`ifndef PTMR_MAP_SVH
`define PTMR_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PTMR_OFF_CTRL0 8'h00
`define PTMR_OFF_CTRL1 8'h04
`define PTMR_OFF_COUNT 8'h08
`define PTMR_OFF_CMPA 8'h0c
`define PTMR_OFF_PER_LO 8'h10
`define PTMR_OFF_PER_HI 8'h14
`define PTMR_OFF_FLAGS 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTMR_CTRL0_ON 3
`define PTMR_CTRL0_CKS_LO 4
`define PTMR_CTRL0_CKS_HI 5
`define PTMR_FLAG_A 0
`define PTMR_FLAG_P 1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PTMR_CNT_W 10
`define PTMR_CNT_MAX 10'h3ff
`define PTMR_RST_CTRL 8'h00
`define PTMR_RST_VAL 10'h000
`define PTMR_RST_PER_HI 8'h00
`define PTMR_PRESCALE 4

`endif

// File: verilog/ptmr_pkg.sv
// Types shared by the periodic timer
package ptmr_pkg;

    // Operating mode codes as held in the mode field
    typedef enum logic [1:0] {
        PTMR_MODE_CMP = 2'h0,
        PTMR_MODE_CAP = 2'h1,
        PTMR_MODE_PWM = 2'h2,
        PTMR_MODE_TC = 2'h3
    } ptmr_mode_t;

    // Timer clock source select
    typedef enum logic [1:0] {
        PTMR_CK_SYS = 2'h0,
        PTMR_CK_DIV = 2'h1,
        PTMR_CK_PIN_RISE = 2'h2,
        PTMR_CK_PIN_FALL = 2'h3
    } ptmr_cksel_t;

    // Control register 1 layout
    typedef struct packed {
        ptmr_mode_t mode_select;
        logic [1:0] pin_function;
        logic initial_level;
        logic output_invert;
        logic capture_source_select;
        logic clear_source_select;
    } ptmr_ctrl_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ptmr_apb_req_t;

endpackage

// File: test/ptmr_pins.sv
// Model of the external io and clock pins of the timer
`timescale 1ns/1ps
`default_nettype none

module ptmr_pins (
    // Clock and commands
    input wire logic clk,
    input wire logic io_req,
    input wire logic ck_req,
    input wire logic slow,
    // Pins
    output logic io_pin,
    output logic ck_pin
);
    logic [2:0] io_cnt;
    logic [2:0] ck_cnt;

    initial begin
        io_pin = 1'b0;
        ck_pin = 1'b0;
        io_cnt = 3'h0;
        ck_cnt = 3'h0;
    end

    // A request toggles its pin one or five cycles later
    always @(posedge clk) begin
        if (io_req) io_cnt <= slow ? 3'h5 : 3'h1;
        else if (io_cnt != 3'h0) io_cnt <= io_cnt - 3'h1;
        if (io_cnt == 3'h1) io_pin <= ~io_pin;
        if (ck_req) ck_cnt <= slow ? 3'h5 : 3'h1;
        else if (ck_cnt != 3'h0) ck_cnt <= ck_cnt - 3'h1;
        if (ck_cnt == 3'h1) ck_pin <= ~ck_pin;
    end
endmodule // ptmr_pins

`default_nettype wire

// File: test/ptmr_timer_chk.sv
// Port-level assertions for the periodic timer
`timescale 1ns/1ps
`default_nettype none

module ptmr_timer_chk #(
    parameter int PRESCALE = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB
    input wire ptmr_pkg::ptmr_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic timer_io_pin_in,
    input wire logic timer_io_pin_out,
    input wire logic timer_io_pin_oe_n,
    input wire logic timer_clock_pin
);
    import ptmr_pkg::*;

    logic wr_ok;
    logic [7:0] c1_reg;
    logic on_reg;
    logic [1:0] age_reg;

    // Shadow of the control writes; age counts settled cycles since one
    assign wr_ok = apb_req.psel && apb_req.penable && pready
        && apb_req.pwrite && !pslverr;

    always_ff @(posedge clk) begin
        if (rst) c1_reg <= 8'h00;
        else if (wr_ok && apb_req.paddr == 8'h04) c1_reg <= apb_req.pwdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (rst) on_reg <= 1'b0;
        else if (wr_ok && apb_req.paddr == 8'h00) on_reg <= apb_req.pwdata[3];
    end

    always_ff @(posedge clk) begin
        if (rst) age_reg <= 2'h0;
        else if (wr_ok && apb_req.paddr[7:3] == 5'h00) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_wait: assert property (apb_req.psel && apb_req.penable && !pready
        |=> pready) else $error("no answer in second access cycle");
    a_setup_quiet: assert property (apb_req.psel && !apb_req.penable
        |=> !pready) else $error("answer in first access cycle");
    a_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    a_init_level: assert property (wr_ok && apb_req.paddr == 8'h00
        && apb_req.pwdata[3] && !on_reg && c1_reg[7:6] == 2'h0 && !c1_reg[2]
        |-> ##3 timer_io_pin_out == c1_reg[3])
        else $error("pin not at initial level after start");
    a_pin_enable: assert property (age_reg == 2'h3
        |-> timer_io_pin_oe_n == c1_reg[6])
        else $error("pin enable wrong for mode");
    a_pwm_forced: assert property (age_reg == 2'h3 && on_reg
        && c1_reg[7:5] == 3'h4
        |-> timer_io_pin_out == (c1_reg[3] ^ c1_reg[2] ^ !c1_reg[4]))
        else $error("forced pwm level wrong");
    a_no_change: assert property (age_reg == 2'h3
        && $past(age_reg) == 2'h3 && c1_reg[7:4] == 4'h0
        |-> $stable(timer_io_pin_out))
        else $error("pin moved with no-change function");
endmodule // ptmr_timer_chk

bind ptmr_timer ptmr_timer_chk #(.PRESCALE(PRESCALE)) u_chk (
    .clk(clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_io_pin_in(timer_io_pin_in),
    .timer_io_pin_out(timer_io_pin_out),
    .timer_io_pin_oe_n(timer_io_pin_oe_n),
    .timer_clock_pin(timer_clock_pin));

`default_nettype wire

// File: test/ptmr_timer_bench.sv
// Self-checking bench of the periodic timer
`timescale 1ns/1ps
`default_nettype none

module ptmr_timer_bench;
    import ptmr_pkg::*;

    logic clk, rst, pready, pslverr, io_in, io_out, oe_n, ck_pin;
    logic io_req, ck_req, slow;
    logic [31:0] prdata, seed;
    ptmr_apb_req_t req;
    logic [32:0] q[$];
    int err_total, n_checks, i;

    ptmr_timer u_dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_io_pin_in(io_in),
        .timer_io_pin_out(io_out), .timer_io_pin_oe_n(oe_n),
        .timer_clock_pin(ck_pin));
    ptmr_pins u_pins (.clk(clk), .io_req(io_req), .ck_req(ck_req),
        .slow(slow), .io_pin(io_in), .ck_pin(ck_pin));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [32:0] s,
        input logic [32:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer, entered just after a rising edge; only the
    // watchdog ends a wait for pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Toggle a pin through the model, at a random pace
    task automatic pin(input logic ck);
        seed = nxt(seed);
        slow <= seed[0];
        if (ck) ck_req <= 1'b1;
        else io_req <= 1'b1;
        @(posedge clk);
        ck_req <= 1'b0;
        io_req <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    always @(posedge clk)
        if (pready === 1'b1 && req.pwrite === 1'b0 && q.size() > 0)
            check("read", {pslverr, prdata}, q.pop_front());

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(50 * 20000);
        err_total++;
        complete_run();
    end

    initial begin
        req = '0;
        {io_req, ck_req, slow} = 3'h0;
        {err_total, n_checks} = '0;
        seed = 32'h946184bc;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 7; i++) rd(8'(i * 4), 33'h0);
        rd(8'h1c, {1'b1, 32'h0});
        seed = nxt(seed);
        wr(8'h0c, seed);
        rd(8'h0c, {23'h0, seed[9:0]});
        wr(8'h14, 32'hff);
        rd(8'h14, 33'h3);
        wr(8'h14, 32'h0);
        // Compare mode clearing on P, then on A with pin left alone
        wr(8'h10, 32'd20);
        wr(8'h0c, 32'd5);
        wr(8'h04, 32'h30);
        wr(8'h00, 32'h08);
        repeat (100) @(posedge clk);
        rd(8'h18, 33'h3);
        wr(8'h00, 32'h0);
        wr(8'h18, 32'h3);
        wr(8'h10, 32'd3);
        wr(8'h0c, 32'd10);
        wr(8'h04, 32'h09);
        wr(8'h00, 32'h08);
        repeat (100) @(posedge clk);
        check("pin", {31'h0, oe_n, io_out}, 33'h1);
        rd(8'h18, 33'h1);
        // Timer mode with compare A zero runs to the top without A flag
        wr(8'h00, 32'h0);
        wr(8'h18, 32'h3);
        wr(8'h04, 32'hc1);
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h08);
        repeat (1100) @(posedge clk);
        check("pin", {31'h0, oe_n, io_out}, 33'h2);
        rd(8'h18, 33'h0);
        // Capture on the io pin, counter clocked by the clock pin
        wr(8'h10, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr(8'h00, 32'h0);
            wr(8'h18, 32'h3);
            wr(8'h0c, 32'h3ff);
            wr(8'h04, 32'(8'h40 | (i << 4)));
            wr(8'h00, 32'h28);
            repeat (2 * (i + 2)) pin(1'b1);
            pin(1'b0);
            rd(8'h0c, (i < 3) ? 33'(i + 2) : 33'h3ff);
            rd(8'h08, 33'(i + 2));
            rd(8'h18, (i < 3) ? 33'h1 : 33'h0);
        end
        // Single pulse fired from the clock pin, ended by A match
        wr(8'h00, 32'h0);
        wr(8'h18, 32'h3);
        wr(8'h0c, 32'd8);
        wr(8'h04, 32'hb8);
        pin(1'b1);
        pin(1'b1);
        repeat (40) @(posedge clk);
        rd(8'h00, 33'h0);
        rd(8'h18, 33'h1);
        // PWM, then forced levels with the counter still running
        wr(8'h18, 32'h3);
        wr(8'h10, 32'd16);
        wr(8'h0c, 32'd4);
        wr(8'h04, 32'ha8);
        wr(8'h00, 32'h08);
        repeat (100) @(posedge clk);
        rd(8'h18, 33'h3);
        for (i = 0; i < 4; i++) begin
            wr(8'h04, 32'(8'h88 | ((i & 1) << 4) | ((i & 2) << 1)));
            wr(8'h18, 32'h3);
            repeat (60) @(posedge clk);
            // Active level high; function bit forces it, invert flips it
            check("pin", {31'h0, oe_n, io_out},
                33'((i ^ (i >> 1)) & 1));
            rd(8'h18, 33'h3);
        end
        complete_run();
    end
endmodule // ptmr_timer_bench

`default_nettype wire
